// ---- hdl/sdbc_pkg.sv ----
// sdbc_pkg: constants, command codes and state types for the bank command logic.
// assumes a single 10 MHz clock; all times are rounded to whole cycles here.
package sdbc_pkg;
	localparam int N_BANKS = 4;
	localparam int BA_W = 2;
	localparam int CNT_W = 8;
	localparam int COL_W_DEF = 8;
	localparam int READ_LATENCY_DEF = 2;
	localparam int BURST_LEN_DEF = 4;
	localparam int CLK_PERIOD_NS = 100;
	// plain defaults, adjust to the part in use
	localparam int ACTIVATE_TO_COLUMN_DELAY_NS = 20;
	localparam int PRECHARGE_TIME_NS = 20;
	localparam int WRITE_RECOVERY_TIME_NS = 15;
	localparam int SELF_REFRESH_EXIT_TIME_NS = 75;
	localparam int SR_EXIT_NOPS = 2;

	// least times round up, never below one cycle
	function automatic int ns_to_cyc(input int t_ns);
		int c;
		c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction : ns_to_cyc

	localparam int RCD_CYC = ns_to_cyc(ACTIVATE_TO_COLUMN_DELAY_NS);
	localparam int RP_CYC = ns_to_cyc(PRECHARGE_TIME_NS);
	localparam int WR_CYC = ns_to_cyc(WRITE_RECOVERY_TIME_NS);
	localparam int XSR_RAW = ns_to_cyc(SELF_REFRESH_EXIT_TIME_NS);
	localparam int XSR_CYC = (XSR_RAW < SR_EXIT_NOPS) ? SR_EXIT_NOPS : XSR_RAW;

	// strobe patterns, row strobe / column strobe / write enable
	localparam logic [2:0] STB_ACT = 3'h3;
	localparam logic [2:0] STB_READ = 3'h5;
	localparam logic [2:0] STB_WRITE = 3'h4;
	localparam logic [2:0] STB_PRE = 3'h2;
	localparam logic [2:0] STB_REFRESH = 3'h1;
	localparam logic [2:0] STB_LMR = 3'h0;
	localparam logic [2:0] STB_BT = 3'h6;
	localparam logic [2:0] STB_NOP = 3'h7;

	typedef enum logic [3:0] {
		C_INHIBIT, C_NOP, C_ACT, C_READ, C_WRITE, C_PRE, C_REFRESH, C_LMR, C_BT
	} sdbc_cmd_t;

	typedef enum logic [4:0] {
		BK_IDLE = 5'h01, BK_OPENING = 5'h02, BK_OPEN = 5'h04, BK_RECOV = 5'h08,
		BK_CLOSING = 5'h10
	} sdbc_bank_t;

	typedef enum logic [4:0] {
		PWR_ON = 5'h01, PWR_PD = 5'h02, PWR_SR = 5'h04, PWR_SRX = 5'h08, PWR_SUSP = 5'h10
	} sdbc_pwr_t;

	function automatic sdbc_cmd_t sdbc_decode(input logic cs_n, input logic [2:0] stb);
		sdbc_cmd_t c;
		c = C_INHIBIT;
		if (!cs_n)
		begin
			unique case (stb)
				STB_NOP: c = C_NOP;
				STB_ACT: c = C_ACT;
				STB_READ: c = C_READ;
				STB_WRITE: c = C_WRITE;
				STB_PRE: c = C_PRE;
				STB_REFRESH: c = C_REFRESH;
				STB_LMR: c = C_LMR;
				STB_BT: c = C_BT;
			endcase
		end
		return c;
	endfunction : sdbc_decode
endpackage : sdbc_pkg

// ---- hdl/sdbc_strm_if.sv ----
// sdbc_strm_if: valid/ready word stream between the read pipeline and its buffer.
// assumes one clock shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface sdbc_strm_if #(parameter int W = 10);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : sdbc_strm_if
`default_nettype wire

// ---- hdl/sdbc_bank.sv ----
// sdbc_bank: state record of one bank, with one timer shared by activate, recovery and precharge.
// assumes commands arrive already qualified by the top-level command logic.
`timescale 1ns/1ps
`default_nettype none
module sdbc_bank import sdbc_pkg::*; #(
	parameter int RCD = RCD_CYC,
	parameter int RP = RP_CYC,
	parameter int WR = WR_CYC
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic en,
	input wire logic act,
	input wire logic pre,
	input wire logic pre_late,
	output logic idle,
	output logic prechg,
	output logic recov
);
	sdbc_bank_t state, next_state;
	logic [CNT_W-1:0] timer, next_timer;
	wire logic done = (timer == '0);

	always_comb
	begin
		next_state = state;
		next_timer = done ? timer : timer - CNT_W'(1);
		if (pre)
		begin
			next_state = BK_CLOSING;
			next_timer = CNT_W'(RP - 1);
		end
		else if (pre_late)
		begin
			next_state = BK_RECOV;
			next_timer = CNT_W'(WR - 1);
		end
		else
		begin
			unique case (state)
				BK_IDLE: if (act) begin next_state = BK_OPENING; next_timer = CNT_W'(RCD - 1); end
				BK_OPENING: if (done) next_state = BK_OPEN;
				BK_OPEN: next_state = BK_OPEN;
				BK_RECOV: if (done) begin next_state = BK_CLOSING; next_timer = CNT_W'(RP - 1); end
				BK_CLOSING: if (done) next_state = BK_IDLE;
				default: next_state = BK_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			state <= BK_IDLE;
			timer <= '0;
		end
		else if (en)
		begin
			state <= next_state;
			timer <= next_timer;
		end
	end

	assign idle = (state == BK_IDLE);
	assign prechg = (state == BK_CLOSING);
	assign recov = (state == BK_RECOV);
endmodule : sdbc_bank
`default_nettype wire

// ---- hdl/sdbc_fifo.sv ----
// sdbc_fifo: small read-data buffer, stream in through the interface, plain ports out.
// assumes the draining side may hold ready low for any time.
`timescale 1ns/1ps
`default_nettype none
module sdbc_fifo #(
	parameter int W = 10,
	parameter int DEPTH = 2
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic en,
	sdbc_strm_if.snk in_s,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	logic [W-1:0] mem [DEPTH];
	logic [PW-1:0] wp, rp;
	logic [CW-1:0] count;
	wire logic push = en && in_s.valid && in_s.ready;
	wire logic pop = en && out_valid && out_ready;

	assign in_s.ready = (count != CW'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rp];

	always_ff @(posedge clk)
	begin
		if (push)
			mem[wp] <= in_s.data;
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			wp <= '0;
			rp <= '0;
			count <= '0;
		end
		else
		begin
			if (push)
				wp <= (wp == PW'(DEPTH - 1)) ? '0 : wp + PW'(1);
			if (pop)
				rp <= (rp == PW'(DEPTH - 1)) ? '0 : rp + PW'(1);
			count <= count + CW'(push) - CW'(pop);
		end
	end
endmodule : sdbc_fifo
`default_nettype wire

// ---- hdl/sdbc_top.sv ----
// sdbc_top: command decode, per-bank state, burst interplay and clock-enable handling
// of a four-bank synchronous dram, with read data leaving through a two-entry buffer.
// assumes all pins synchronous to SYS_CLK and a controller that keeps its own timing.
// Notes on behaviour
// - chip select high is inhibit; running operations carry on.
// - chip select low with all strobes high is a no-operation.
// - strobe patterns decode to activate, read, write and precharge.
// - with bank n idle, bank m takes any command its state permits.
// - other banks accept activate, read, write, precharge while bank n is busy.
// - burst terminate acts only on the running burst, never another bank.
// - precharge to another bank leaves the running burst untouched.
// - interrupting an auto-precharge burst starts that bank's precharge internally.
// - read interrupting a read takes the output one read latency later.
// - write interrupting a read ends it when registered; mask one clock earlier.
// - read interrupting a write stops it; last write word one clock before.
// - write interrupting a write ends it; last old word the clock before.
// - read over a read with auto precharge precharges bank n at once.
// - write over a read with auto precharge ends it, precharges bank n.
// - read over a write with auto precharge: precharge after write recovery.
// - write over a write with auto precharge: precharge after write recovery.
// - clock enable low at both edges holds power-down, self refresh or suspend.
// - all idle, enable falling: nop enters power-down, refresh enters self refresh.
// - power-down exit at edge n leaves all banks ready at edge n+1.
// - enable low during a burst suspends it; resumes the edge after return.
// - burst terminate cuts off the most recently started burst.
`timescale 1ns/1ps
`default_nettype none
module sdbc_top import sdbc_pkg::*; #(
	parameter int RD_LAT = READ_LATENCY_DEF,
	parameter int BURST_LEN = BURST_LEN_DEF,
	parameter int COL_W = COL_W_DEF
) (
	input wire logic SYS_CLK,
	input wire logic NRST,
	input wire logic CLK_EN,
	input wire logic CKE,
	input wire logic CS_N,
	input wire logic RAS_N,
	input wire logic CAS_N,
	input wire logic WE_N,
	input wire logic [BA_W-1:0] BA,
	input wire logic AUTO_PRE,
	input wire logic [COL_W-1:0] COL,
	input wire logic DQM,
	output logic RD_VALID,
	input wire logic RD_READY,
	output logic [BA_W+COL_W-1:0] RD_DATA,
	output logic WR_STROBE,
	output logic [BA_W-1:0] WR_BANK,
	output logic [COL_W-1:0] WR_COL,
	output logic ALL_IDLE,
	output logic POWER_DOWN,
	output logic SELF_REFRESH,
	output logic CLOCK_SUSPEND,
	output logic CMD_READY
);
	localparam int DATA_W = BA_W + COL_W;
	localparam int WR_DLY = WR_CYC;

	sdbc_cmd_t cmd;
	sdbc_pwr_t pwr, next_pwr;
	logic cke_prev;
	logic [CNT_W-1:0] xsr_cnt, next_xsr_cnt;
	logic burst_on, burst_rd, burst_ap;
	logic [BA_W-1:0] burst_bank;
	logic [COL_W-1:0] burst_col;
	logic [CNT_W-1:0] beat;
	logic [N_BANKS-1:0] bk_act, bk_pre, bk_pre_late, bk_idle, bk_prechg, bk_recov;
	logic [RD_LAT-1:0] pipe_v;
	logic [DATA_W-1:0] pipe_d [RD_LAT];
	sdbc_strm_if #(.W(DATA_W)) rd_s ();

	wire logic nop_like;
	wire logic all_idle;
	wire logic cmd_ok;
	wire logic run;
	wire logic rd_go, wr_go, bt_go, pre_go, act_go, col_go;
	wire logic beat_last, cont, burst_end, interrupt_ap, end_ap, ap_fire;
	wire logic rd_issue, wr_issue;
	wire logic [BA_W-1:0] cur_bank;
	wire logic [COL_W-1:0] cur_col;

	assign cmd = sdbc_decode(CS_N, {RAS_N, CAS_N, WE_N});
	assign nop_like = (cmd == C_INHIBIT) || (cmd == C_NOP);
	assign all_idle = &bk_idle;
	// commands count only with enable high at this edge and the previous one
	assign cmd_ok = (pwr == PWR_ON) && cke_prev && CKE;
	// a full buffer with a word waiting in the last pipe stage stalls the whole command path: simpler than dropping read words,
	// but the controller must watch CMD_READY
	assign run = cmd_ok && (rd_s.ready || !pipe_v[RD_LAT-1]);
	assign rd_go = run && (cmd == C_READ);
	assign wr_go = run && (cmd == C_WRITE);
	assign bt_go = run && (cmd == C_BT);
	assign pre_go = run && (cmd == C_PRE);
	assign act_go = run && (cmd == C_ACT);
	assign col_go = rd_go || wr_go;

	assign beat_last = (beat == CNT_W'(BURST_LEN - 1));
	// the running burst goes on unless a new column command or terminate arrives
	assign cont = burst_on && !col_go && !bt_go;
	assign burst_end = run && cont && beat_last;
	// a new burst to another bank cuts an auto-precharge burst short
	assign interrupt_ap = col_go && burst_on && burst_ap && (burst_bank != BA);
	assign end_ap = burst_end && burst_ap;
	assign ap_fire = interrupt_ap || end_ap;
	assign rd_issue = rd_go || (run && cont && burst_rd);
	assign wr_issue = wr_go || (run && cont && !burst_rd);
	assign cur_bank = col_go ? BA : burst_bank;
	assign cur_col = col_go ? COL : burst_col + COL_W'(beat);

	genvar i;
	generate
		for (i = 0; i < N_BANKS; i++)
		begin : g_bank
			wire logic hit = (BA == BA_W'(i));
			wire logic own = (burst_bank == BA_W'(i));
			assign bk_act[i] = act_go && hit;
			// read bursts precharge on interruption, write bursts wait out recovery
			assign bk_pre[i] = (pre_go && (AUTO_PRE || hit)) || (ap_fire && burst_rd && own);
			assign bk_pre_late[i] = ap_fire && !burst_rd && own;
			sdbc_bank #(.RCD(RCD_CYC), .RP(RP_CYC), .WR(WR_CYC)) u_bank (
				.clk(SYS_CLK),
				.nrst(NRST),
				.en(CLK_EN),
				.act(bk_act[i]),
				.pre(bk_pre[i]),
				.pre_late(bk_pre_late[i]),
				.idle(bk_idle[i]),
				.prechg(bk_prechg[i]),
				.recov(bk_recov[i])
			);
		end
	endgenerate

	// single record of the most recent burst, whichever bank it belongs to
	always_ff @(posedge SYS_CLK)
	begin
		if (!NRST)
		begin
			burst_on <= 1'b0;
			burst_rd <= 1'b0;
			burst_ap <= 1'b0;
			burst_bank <= '0;
			burst_col <= '0;
			beat <= '0;
		end
		else if (CLK_EN && run)
		begin
			if (col_go)
			begin
				burst_on <= 1'b1;
				burst_rd <= rd_go;
				burst_ap <= AUTO_PRE;
				burst_bank <= BA;
				burst_col <= COL;
				beat <= CNT_W'(1);
			end
			else if (bt_go || burst_end)
				burst_on <= 1'b0;
			else if (burst_on)
				beat <= beat + CNT_W'(1);
		end
	end

	// read pipeline: a word issued at edge n leaves the last stage read latency later,
	// so an older burst keeps the output until the new one arrives
	always_ff @(posedge SYS_CLK)
	begin
		if (!NRST)
			pipe_v[0] <= 1'b0;
		else if (CLK_EN && run)
			pipe_v[0] <= rd_issue && !wr_go;
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (CLK_EN && run)
			pipe_d[0] <= {cur_bank, cur_col};
	end

	genvar k;
	generate
		for (k = 1; k < RD_LAT; k++)
		begin : g_pipe
			always_ff @(posedge SYS_CLK)
			begin
				if (!NRST)
					pipe_v[k] <= 1'b0;
				else if (CLK_EN && run)
					pipe_v[k] <= pipe_v[k-1] && !wr_go;
			end
			always_ff @(posedge SYS_CLK)
			begin
				if (CLK_EN && run)
					pipe_d[k] <= pipe_d[k-1];
			end
		end
	endgenerate

	assign rd_s.valid = pipe_v[RD_LAT-1] && cmd_ok;
	assign rd_s.data = pipe_d[RD_LAT-1];

	sdbc_fifo #(.W(DATA_W), .DEPTH(2)) u_fifo (
		.clk(SYS_CLK),
		.nrst(NRST),
		.en(CLK_EN),
		.in_s(rd_s),
		.out_valid(RD_VALID),
		.out_ready(RD_READY),
		.out_data(RD_DATA)
	);

	// write capture: a new column command owns its own edge, so the old burst's last
	// word is the one taken on the clock before
	always_ff @(posedge SYS_CLK)
	begin
		if (!NRST)
		begin
			WR_STROBE <= 1'b0;
			WR_BANK <= '0;
			WR_COL <= '0;
		end
		else if (CLK_EN)
		begin
			WR_STROBE <= wr_issue && run && !DQM;
			WR_BANK <= cur_bank;
			WR_COL <= cur_col;
		end
	end

	always_comb
	begin
		next_pwr = pwr;
		next_xsr_cnt = xsr_cnt;
		unique case (pwr)
			PWR_ON:
				if (cke_prev && !CKE)
				begin
					if (burst_on)
						next_pwr = PWR_SUSP;
					else if (all_idle && nop_like)
						next_pwr = PWR_PD;
					else if (all_idle && (cmd == C_REFRESH))
						next_pwr = PWR_SR;
				end
			PWR_PD:
				if (CKE && nop_like)
					next_pwr = PWR_ON;
			PWR_SR:
				if (CKE && nop_like)
				begin
					next_pwr = PWR_SRX;
					next_xsr_cnt = CNT_W'(XSR_CYC - 1);
				end
			// commands are ignored here whatever the controller sends
			PWR_SRX:
				if (xsr_cnt == '0)
					next_pwr = PWR_ON;
				else
					next_xsr_cnt = xsr_cnt - CNT_W'(1);
			PWR_SUSP:
				if (CKE)
					next_pwr = PWR_ON;
			default: next_pwr = PWR_ON;
		endcase
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (!NRST)
		begin
			pwr <= PWR_ON;
			cke_prev <= 1'b0;
			xsr_cnt <= '0;
		end
		else if (CLK_EN)
		begin
			pwr <= next_pwr;
			cke_prev <= CKE;
			xsr_cnt <= next_xsr_cnt;
		end
	end

	assign ALL_IDLE = all_idle;
	assign POWER_DOWN = (pwr == PWR_PD);
	assign SELF_REFRESH = (pwr == PWR_SR) || (pwr == PWR_SRX);
	assign CLOCK_SUSPEND = (pwr == PWR_SUSP);
	assign CMD_READY = run;

	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!NRST);

	inhibit_keeps_a: assert property ((CLK_EN && run && CS_N && burst_on && !beat_last)
		|=> burst_on && (beat == $past(beat) + CNT_W'(1)) && $stable(burst_bank))
		else $error("inhibit disturbed running burst");
	nop_keeps_a: assert property ((CLK_EN && run && (cmd == C_NOP) && burst_on && beat_last)
		|=> !burst_on && $stable(burst_bank))
		else $error("nop did not let burst finish");
	read_decode_a: assert property ((CLK_EN && run && !CS_N && RAS_N && !CAS_N && WE_N)
		|=> burst_on && burst_rd && (burst_bank == $past(BA)) && pipe_v[0])
		else $error("read strobes not decoded as read");
	act_other_a: assert property ((CLK_EN && act_go && bk_idle[BA])
		|=> !bk_idle[$past(BA)])
		else $error("activate to idle bank ignored");
	bt_cut_a: assert property ((CLK_EN && bt_go && burst_on) |=> !burst_on)
		else $error("burst terminate left burst running");
	pre_other_a: assert property ((CLK_EN && pre_go && !AUTO_PRE && (BA != burst_bank)
		&& burst_on && !beat_last) |=> burst_on && (burst_rd == $past(burst_rd)))
		else $error("precharge to other bank disturbed burst");
	wr_flush_a: assert property ((CLK_EN && wr_go) |=> (pipe_v == '0) && !burst_rd)
		else $error("write did not end read data");
	rd_stops_wr_a: assert property ((CLK_EN && rd_go && burst_on && !burst_rd)
		|=> !WR_STROBE)
		else $error("write capture after interrupting read");
	ap_read_a: assert property ((CLK_EN && interrupt_ap && burst_rd)
		|=> bk_prechg[$past(burst_bank)])
		else $error("auto precharge not started on read interrupt");
	ap_write_a: assert property ((CLK_EN && interrupt_ap && !burst_rd)
		|=> bk_recov[$past(burst_bank)] ##WR_DLY bk_prechg[$past(burst_bank, WR_DLY + 1)])
		else $error("write recovery before precharge wrong");
	cke_hold_a: assert property ((CLK_EN && !cke_prev && !CKE
		&& (pwr inside {PWR_PD, PWR_SR, PWR_SUSP})) |=> $stable(pwr) && !CMD_READY)
		else $error("low clock enable left power state");
	sr_entry_a: assert property ((CLK_EN && (pwr == PWR_ON) && cke_prev && !CKE && !burst_on
		&& all_idle && (cmd == C_REFRESH)) |=> (pwr == PWR_SR))
		else $error("self refresh not entered");
	pd_exit_a: assert property ((CLK_EN && (pwr == PWR_PD) && CKE && nop_like)
		|=> (pwr == PWR_ON) && all_idle)
		else $error("power-down exit not ready next edge");
	suspend_a: assert property ((CLK_EN && (pwr == PWR_ON) && cke_prev && !CKE && burst_on)
		|=> (pwr == PWR_SUSP) && (beat == $past(beat)))
		else $error("clock suspend did not freeze burst");
endmodule : sdbc_top
`default_nettype wire

// ---- tb/sdbc_ctl_model.sv ----
// sdbc_ctl_model: command side of a memory controller that drives the bank command logic.
// assumes one clock, with every pin change landing 1 ns after the rising edge.
`timescale 1ns/1ps
`default_nettype none
module sdbc_ctl_model import sdbc_pkg::*; (
	input wire logic clk,
	input wire logic all_idle,
	output logic cke,
	output logic cs_n,
	output logic [2:0] stb,
	output logic [BA_W-1:0] ba,
	output logic auto_pre,
	output logic [COL_W_DEF-1:0] col,
	output logic dqm
);
	initial
	begin
		cke = 1'h1;
		cs_n = 1'h0;
		stb = STB_NOP;
		ba = 2'h0;
		auto_pre = 1'h0;
		col = 8'h0;
		dqm = 1'h0;
	end

	// refresh and load-mode commands fall back to a nop unless every bank is idle
	task automatic issue(input logic [2:0] s, input logic [1:0] b, input logic [7:0] c,
		input logic a, input logic m, input logic k, input logic sel_n);
		logic [2:0] use_s;
		use_s = ((s == STB_REFRESH || s == STB_LMR) && !all_idle) ? STB_NOP : s;
		@(posedge clk);
		#1;
		cke = k;
		cs_n = sel_n;
		stb = use_s;
		ba = b;
		auto_pre = a;
		col = c;
		dqm = m;
	endtask : issue

	// address lines mean nothing during a nop, so they toggle rather than hold
	task automatic nops(input int n, input logic m, input logic k);
		repeat (n)
		begin
			@(posedge clk);
			#1;
			cke = k;
			cs_n = 1'h0;
			stb = STB_NOP;
			ba = ~ba;
			col = ~col;
			auto_pre = ~auto_pre;
			dqm = m;
		end
	endtask : nops

	// self refresh exit: nops over the whole exit time, never fewer than two
	task automatic sr_leave();
		nops(XSR_CYC, 1'h0, 1'h1);
	endtask : sr_leave
endmodule : sdbc_ctl_model
`default_nettype wire

// ---- tb/sdbc_top_tb_top.sv ----
// sdbc_top_tb_top: self-checking bench for the bank command logic with a queue model.
// assumes sdbc_ctl_model drives the command pins and the bench drains the read stream.
`timescale 1ns/1ps
`default_nettype none
module sdbc_top_tb_top import sdbc_pkg::*;;
	logic sys_clk = 1'h0;
	logic nrst = 1'h0;
	logic clk_en = 1'h1;
	logic rd_ready = 1'h1;
	logic cke, cs_n, dqm, auto_pre;
	logic [2:0] stb;
	logic [1:0] ba, wr_bank, mb;
	logic [7:0] col, wr_col, mc;
	logic [9:0] rd_data;
	logic rd_valid, wr_strobe, all_idle, power_down, self_refresh, clock_suspend, cmd_ready;
	int errors = 0;
	int total_checks = 0;
	int left = 0;
	logic is_rd = 1'h0;
	logic ckp = 1'h0;
	logic rd_last = 1'h0;
	logic [15:0] lfsr = 16'h0030;
	logic [9:0] exp_rd[$];
	logic [9:0] exp_wr[$];

	always #50 sys_clk = ~sys_clk;

	sdbc_ctl_model i_ctl (.clk(sys_clk), .all_idle(all_idle), .cke(cke), .cs_n(cs_n),
		.stb(stb), .ba(ba), .auto_pre(auto_pre), .col(col), .dqm(dqm));

	sdbc_top i_dut (.SYS_CLK(sys_clk), .NRST(nrst), .CLK_EN(clk_en), .CKE(cke), .CS_N(cs_n),
		.RAS_N(stb[2]), .CAS_N(stb[1]), .WE_N(stb[0]), .BA(ba), .AUTO_PRE(auto_pre),
		.COL(col), .DQM(dqm), .RD_VALID(rd_valid), .RD_READY(rd_ready), .RD_DATA(rd_data),
		.WR_STROBE(wr_strobe), .WR_BANK(wr_bank), .WR_COL(wr_col), .ALL_IDLE(all_idle),
		.POWER_DOWN(power_down), .SELF_REFRESH(self_refresh),
		.CLOCK_SUSPEND(clock_suspend), .CMD_READY(cmd_ready));

	function automatic logic [15:0] lfsr_next(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : lfsr_next

	task automatic report_and_stop();
		if (errors == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop

	task automatic chk_word(input string name, input logic [9:0] e, input logic [9:0] g);
		total_checks++;
		if (g !== e)
		begin
			errors++;
			$display("BAD %s exp %h got %h", name, e, g);
		end
	endtask : chk_word

	task automatic chk_flag(input string name, input logic e, input logic g);
		total_checks++;
		if (g !== e)
		begin
			errors++;
			$display("BAD %s exp %b got %b", name, e, g);
		end
	endtask : chk_flag

	task automatic tick();
		@(posedge sys_clk);
		#1;
	endtask : tick

	task automatic cmd(input logic [2:0] s, input logic [1:0] b, input logic [7:0] c,
		input logic a);
		i_ctl.issue(s, b, c, a, 1'h0, 1'h1, 1'h0);
	endtask : cmd

	task automatic wait_ready();
		int n;
		n = 0;
		while (cmd_ready !== 1'h1)
		begin
			if (n == 20)
			begin
				chk_flag("cmd_ready_wait", 1'h1, cmd_ready);
				report_and_stop();
			end
			tick();
			n++;
		end
	endtask : wait_ready

	// one burst record, beats counted on enabled edges with clock enable high at both
	always @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			left = 0;
			ckp = 1'h0;
			rd_last = 1'h0;
		end
		else if (clk_en)
		begin
			// a taken write drops the read beat still in the first pipe stage
			if (cke && ckp)
			begin
				if (rd_last && !cs_n && stb == STB_WRITE)
					void'(exp_rd.pop_back());
				rd_last = 1'h0;
			end
			if (cke && ckp && !cs_n && stb[2] && stb != 3'h7)
			begin
				left = stb[1] ? 0 : 4;
				is_rd = stb[0];
				mb = ba;
				mc = col;
			end
			if (left > 0 && cke && ckp)
			begin
				rd_last = is_rd;
				if (is_rd)
					exp_rd.push_back({mb, mc});
				else if (!dqm)
					exp_wr.push_back({mb, mc});
				mc = mc + 8'h1;
				left = left - 1;
			end
			ckp = cke;
			if (rd_valid === 1'h1 && rd_ready)
				chk_word("rd_data", exp_rd.size() ? exp_rd.pop_front() : 10'hx, rd_data);
			if (wr_strobe === 1'h1)
				chk_word("wr_beat", exp_wr.size() ? exp_wr.pop_front() : 10'hx, {wr_bank, wr_col});
		end
	end

	initial
	begin
		logic [15:0] r;
		logic [2:0] s;
		repeat (12) @(posedge sys_clk);
		#1;
		nrst = 1'h1;
		tick();
		chk_flag("all_idle", 1'h1, all_idle);
		chk_flag("rd_valid", 1'h0, rd_valid);
		chk_flag("cmd_ready", 1'h1, cmd_ready);
		for (int b = 0; b < 4; b++)
			cmd(STB_ACT, b[1:0], 8'h0, 1'h0);
		i_ctl.nops(2, 1'h0, 1'h1);
		chk_flag("all_idle", 1'h0, all_idle);
		// every pairing of read and write, plain and with auto precharge on the first
		for (int p = 0; p < 2; p++)
			for (int k = 0; k < 4; k++)
			begin
				cmd(k[1] ? STB_WRITE : STB_READ, 2'h0, 8'h10, p[0]);
				i_ctl.nops(2, k == 1, 1'h1);
				cmd(k[0] ? STB_WRITE : STB_READ, 2'h1, 8'h20, 1'h0);
				i_ctl.nops(6, 1'h0, 1'h1);
				if (p == 1)
					cmd(STB_ACT, 2'h0, 8'h0, 1'h0);
			end
		cmd(STB_READ, 2'h2, 8'h40, 1'h0);
		i_ctl.nops(1, 1'h0, 1'h1);
		cmd(STB_PRE, 2'h3, 8'h0, 1'h0);
		i_ctl.nops(4, 1'h0, 1'h1);
		cmd(STB_READ, 2'h2, 8'h50, 1'h0);
		i_ctl.nops(1, 1'h0, 1'h1);
		cmd(STB_BT, 2'h1, 8'h0, 1'h0);
		i_ctl.nops(4, 1'h0, 1'h1);
		rd_ready = 1'h0;
		cmd(STB_READ, 2'h1, 8'h60, 1'h0);
		i_ctl.nops(6, 1'h0, 1'h1);
		chk_flag("rd_valid", 1'h1, rd_valid);
		chk_flag("cmd_ready", 1'h0, cmd_ready);
		rd_ready = 1'h1;
		i_ctl.nops(8, 1'h0, 1'h1);
		cmd(STB_READ, 2'h2, 8'h80, 1'h0);
		i_ctl.nops(1, 1'h0, 1'h1);
		i_ctl.nops(1, 1'h0, 1'h0);
		tick();
		chk_flag("clock_suspend", 1'h1, clock_suspend);
		i_ctl.nops(2, 1'h0, 1'h0);
		chk_flag("clock_suspend", 1'h1, clock_suspend);
		chk_flag("cmd_ready", 1'h0, cmd_ready);
		i_ctl.nops(1, 1'h0, 1'h1);
		tick();
		chk_flag("cmd_ready", 1'h1, cmd_ready);
		i_ctl.nops(6, 1'h0, 1'h1);
		cmd(STB_PRE, 2'h0, 8'h0, 1'h1);
		i_ctl.nops(3, 1'h0, 1'h1);
		chk_flag("all_idle", 1'h1, all_idle);
		// bank 0 may only close through the concurrent auto precharge
		cmd(STB_ACT, 2'h0, 8'h0, 1'h0);
		cmd(STB_ACT, 2'h1, 8'h0, 1'h0);
		i_ctl.nops(2, 1'h0, 1'h1);
		cmd(STB_WRITE, 2'h0, 8'h90, 1'h1);
		i_ctl.nops(1, 1'h0, 1'h1);
		cmd(STB_READ, 2'h1, 8'ha0, 1'h0);
		i_ctl.nops(6, 1'h0, 1'h1);
		cmd(STB_PRE, 2'h1, 8'h0, 1'h0);
		i_ctl.nops(3, 1'h0, 1'h1);
		chk_flag("all_idle", 1'h1, all_idle);
		i_ctl.nops(1, 1'h0, 1'h0);
		tick();
		chk_flag("power_down", 1'h1, power_down);
		i_ctl.nops(3, 1'h0, 1'h0);
		chk_flag("power_down", 1'h1, power_down);
		i_ctl.nops(1, 1'h0, 1'h1);
		tick();
		chk_flag("cmd_ready", 1'h1, cmd_ready);
		cmd(STB_ACT, 2'h3, 8'h0, 1'h0);
		i_ctl.nops(2, 1'h0, 1'h1);
		chk_flag("all_idle", 1'h0, all_idle);
		cmd(STB_PRE, 2'h0, 8'h0, 1'h1);
		i_ctl.nops(3, 1'h0, 1'h1);
		i_ctl.issue(STB_REFRESH, 2'h0, 8'h0, 1'h0, 1'h0, 1'h0, 1'h0);
		tick();
		chk_flag("self_refresh", 1'h1, self_refresh);
		i_ctl.nops(3, 1'h0, 1'h0);
		chk_flag("self_refresh", 1'h1, self_refresh);
		i_ctl.sr_leave();
		chk_flag("cmd_ready", 1'h0, cmd_ready);
		wait_ready();
		chk_flag("self_refresh", 1'h0, self_refresh);
		for (int b = 0; b < 4; b++)
			cmd(STB_ACT, b[1:0], 8'h0, 1'h0);
		i_ctl.nops(2, 1'h0, 1'h1);
		// random mix; the read stream never stalls here, so only commands on edges with clk_en low are lost
		for (int i = 0; i < 80; i++)
		begin
			lfsr = lfsr_next(lfsr);
			r = lfsr;
			s = (r[2:0] == 3'h4) ? STB_BT : (r[2:1] == 2'h3) ? STB_NOP : r[1] ? STB_WRITE : STB_READ;
			i_ctl.issue(s, r[4:3], {r[10:5], 2'h0}, 1'h0, r[11], 1'h1, r[2:0] == 3'h5);
			clk_en = (r[14:12] != 3'h0);
		end
		tick();
		clk_en = 1'h1;
		i_ctl.nops(12, 1'h0, 1'h1);
		chk_flag("rd_left", 1'h1, exp_rd.size() == 0);
		chk_flag("wr_left", 1'h1, exp_wr.size() == 0);
		report_and_stop();
	end
endmodule : sdbc_top_tb_top
`default_nettype wire
